// ===== logic/pwmd_timer.sv
// Purpose: 10-bit up/down timer with channel D compare output, fault front end and pin mux
// Assumes: registers reached over a byte-wide cpu port; timer runs every clock
// Notes:   pins only drive when the external direction bit is set
// Behaviour
// - nonzero mode puts waveform on pin
// - inverted pin only in pwm with 01, or in six-output through override bit 5
// - non-pwm codes: port, toggle, clear, set
// - fast pwm: clear on match, set at zero
// - dual slope: clear up, set down
// - force applies action in non-pwm, no irq
// - force uses new mode, reads zero
// - pwm enable selects pwm operation
// - separate fault enable and irq enable bits
// - filter needs four equal samples
// - edge select: zero falling, one rising
// - comparator source through same front end
// - flag sets always; irq needs both enables and the flag
// - flag clears on vector or write-one
// - pwm enable and mode field select counting
// - compare update and overflow at mode point
// - override bits connect six pins in six-output
// - reserved bits read as zero, except chd_ctrl bits 7:4, which read back as written
// - 10-bit counter, delayed cpu write
// - counter counts up after write
// - two-bit holding register, 8-bit use possible
// - holding register shared by 10-bit registers
// - top match resets counter outside dual slope (turns it down there), minimum three
`timescale 1ns/1ps
`default_nettype none
module pwmd_timer (
  input  wire logic       sys_clk_i,           // timer clock, 20 MHz
  input  wire logic       sys_rst_i,           // async reset, high
  input  wire logic [5:0] reg_addr_i,          // register address
  input  wire logic [7:0] reg_wdata_i,         // write data
  input  wire logic       reg_wr_i,            // write strobe
  input  wire logic       reg_rd_i,            // read strobe
  output logic      [7:0] reg_rdata_o,         // read data, next cycle
  input  wire logic       global_irq_en_i,     // cpu global interrupt enable
  input  wire logic       fault_vector_ack_i,  // fault vector taken
  input  wire logic       external_fault_pin_i,// fault pin, async
  input  wire logic       comparator_out_i,    // analog comparator, async
  input  wire logic [5:0] port_value_i,        // port register values
  input  wire logic [5:0] port_dir_i,          // pin direction bits
  input  wire logic [3:0] other_waveforms_i,   // a, a inv, b, b inv
  output logic      [5:0] pin_out_o,           // pin levels
  output logic      [5:0] pin_oe_o,            // pin drive enables
  output logic            fault_irq_o,         // fault interrupt request
  output logic            counter_overflow_o,  // overflow pulse
  output logic            chan_d_waveform_o    // channel d waveform
);
  import pwmd_pkg::*;

  pwmd_fault_wave_s fw;
  pwmd_fault_wave_s next_fw;
  logic [7:0]       chd_ctrl;
  logic [7:0]       next_chd_ctrl;
  logic [5:0]       oe_bits;
  logic [5:0]       next_oe_bits;
  logic [1:0]       hold;
  logic [1:0]       next_hold;
  logic [9:0]       top_buf;
  logic [9:0]       next_top_buf;
  logic [9:0]       chd_buf;
  logic [9:0]       next_chd_buf;
  logic             cnt_pend;
  logic             next_cnt_pend;
  logic [9:0]       cnt_val;
  logic [9:0]       next_cnt_val;
  logic             clr_pend;
  logic             next_clr_pend;
  logic [7:0]       next_rdata;
  logic [9:0]       wide_wdata;

  logic [9:0]       count;
  logic [9:0]       next_count;
  logic             count_down;
  logic             next_count_down;
  logic [9:0]       top_act;
  logic [9:0]       next_top_act;
  logic [9:0]       chd_act;
  logic [9:0]       next_chd_act;
  logic             next_ovf;

  logic             wave;
  logic             next_wave;
  logic [5:0]       next_pins;
  logic             next_irq;

  logic             pin_level;
  logic             cmp_level;
  logic             src_level;
  logic             src_prev;
  logic             fault_event;

  pwmd_out_mode_e   mode;
  logic             pwm_en;
  logic             dual;
  logic             six;
  logic             at_top;
  logic             at_bottom;
  logic             update_pt;
  logic             match;
  logic             force_wr;
  pwmd_out_mode_e   force_mode;
  logic [5:0]       six_wave;

  assign mode       = pwmd_out_mode_e'(chd_ctrl[CHD_MODE_HI:CHD_MODE_LO]);
  assign pwm_en     = chd_ctrl[CHD_PWM];
  assign dual       = pwm_en && fw.waveform_mode_sel_lo;
  assign six        = pwm_en && fw.waveform_mode_sel_hi;
  assign wide_wdata = {hold, reg_wdata_i};
  assign force_wr   = reg_wr_i && reg_addr_i == ADDR_CHD_CTRL
                      && reg_wdata_i[CHD_FORCE] && !reg_wdata_i[CHD_PWM];
  assign force_mode = pwmd_out_mode_e'(reg_wdata_i[CHD_MODE_HI:CHD_MODE_LO]);

  // fault front end: both sources conditioned identically
  pwmd_fault_front u_pin_front (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .raw_i       (external_fault_pin_i),
    .filter_en_i (fw.fault_noise_filter_en),
    .level_o     (pin_level)
  );

  pwmd_fault_front u_cmp_front (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .raw_i       (comparator_out_i),
    .filter_en_i (fw.fault_noise_filter_en),
    .level_o     (cmp_level)
  );

  assign src_level   = fw.fault_comparator_source ? cmp_level : pin_level;
  assign fault_event = fw.fault_edge_select ? (src_level && !src_prev)
                                            : (!src_level && src_prev);

  // register file
  always_comb begin
    next_fw       = fw;
    next_chd_ctrl = chd_ctrl;
    next_oe_bits  = oe_bits;
    next_hold     = hold;
    next_top_buf  = top_buf;
    next_chd_buf  = chd_buf;
    next_cnt_pend = 1'b0;
    next_cnt_val  = cnt_val;
    next_clr_pend = 1'b0;
    next_rdata    = reg_rdata_o;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_FAULT_WAVE: next_rdata = fw;
        ADDR_CHD_CTRL:   next_rdata = chd_ctrl & ~(8'h01 << CHD_FORCE);
        ADDR_OVERRIDE:   next_rdata = {2'h0, oe_bits};
        ADDR_HOLD:       next_rdata = {6'h00, hold};
        ADDR_COUNTER: begin
          next_rdata = count[7:0];
          next_hold  = count[9:8];
        end
        ADDR_TOP_CMP: begin
          next_rdata = top_buf[7:0];
          next_hold  = top_buf[9:8];
        end
        ADDR_CHD_CMP: begin
          next_rdata = chd_buf[7:0];
          next_hold  = chd_buf[9:8];
        end
        default:         next_rdata = 8'h00;
      endcase
    end
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_FAULT_WAVE: begin
          next_fw            = pwmd_fault_wave_s'(reg_wdata_i);
          next_fw.fault_flag = fw.fault_flag;
          next_clr_pend      = reg_wdata_i[FLT_FLAG];
        end
        ADDR_CHD_CTRL:   next_chd_ctrl = reg_wdata_i & ~(8'h01 << CHD_FORCE);
        ADDR_OVERRIDE:   next_oe_bits  = reg_wdata_i[5:0];
        ADDR_HOLD:       next_hold     = reg_wdata_i[1:0];
        ADDR_COUNTER: begin
          next_cnt_pend = 1'b1;
          next_cnt_val  = wide_wdata;
        end
        ADDR_TOP_CMP:    next_top_buf  = (wide_wdata < TOP_MIN) ? TOP_MIN : wide_wdata;
        ADDR_CHD_CMP:    next_chd_buf  = wide_wdata;
        default: begin
        end
      endcase
    end
    // a new fault beats a pending clear
    if (fault_event) begin
      next_fw.fault_flag = 1'b1;
    end else if (clr_pend || fault_vector_ack_i) begin
      next_fw.fault_flag = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fw          <= pwmd_fault_wave_s'(CTRL_RESET);
      chd_ctrl    <= CTRL_RESET;
      oe_bits     <= OVERRIDE_RESET;
      hold        <= HOLD_RESET;
      top_buf     <= TOP_RESET;
      chd_buf     <= CHD_CMP_RESET;
      cnt_pend    <= 1'b0;
      cnt_val     <= COUNT_BOTTOM;
      clr_pend    <= 1'b0;
      reg_rdata_o <= 8'h00;
    end else begin
      fw          <= next_fw;
      chd_ctrl    <= next_chd_ctrl;
      oe_bits     <= next_oe_bits;
      hold        <= next_hold;
      top_buf     <= next_top_buf;
      chd_buf     <= next_chd_buf;
      cnt_pend    <= next_cnt_pend;
      cnt_val     <= next_cnt_val;
      clr_pend    <= next_clr_pend;
      reg_rdata_o <= next_rdata;
    end
  end

  // counter
  assign at_top    = !dual && !count_down && count >= top_act;
  assign at_bottom = dual && count_down && count == COUNT_BOTTOM;
  assign update_pt = !pwm_en || (dual ? at_bottom : at_top);
  assign match     = count == chd_act && !cnt_pend;

  always_comb begin
    next_count      = count + 10'h001;
    next_count_down = count_down && dual;  // down-count only survives in dual slope
    next_ovf        = dual ? at_bottom : at_top;
    next_top_act    = update_pt ? top_buf : top_act;
    next_chd_act    = update_pt ? chd_buf : chd_act;
    if (cnt_pend) begin
      next_count      = cnt_val;
      next_count_down = 1'b0;
      next_ovf        = 1'b0;
    end else if (at_top) begin
      next_count = COUNT_BOTTOM;
    end else if (dual && !count_down && count >= top_act) begin
      next_count      = count - 10'h001;
      next_count_down = 1'b1;
    end else if (at_bottom) begin
      next_count_down = 1'b0;
    end else if (count_down) begin
      next_count = count - 10'h001;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count              <= COUNT_BOTTOM;
      count_down         <= 1'b0;
      top_act            <= TOP_RESET;
      chd_act            <= CHD_CMP_RESET;
      counter_overflow_o <= 1'b0;
    end else begin
      count              <= next_count;
      count_down         <= next_count_down;
      top_act            <= next_top_act;
      chd_act            <= next_chd_act;
      counter_overflow_o <= next_ovf;
    end
  end

  // waveform, pins and interrupt
  assign six_wave = {~wave, wave, other_waveforms_i};

  always_comb begin
    next_wave = wave;
    if (force_wr) begin
      unique case (force_mode)
        OM_PORT:   next_wave = wave;
        OM_TOGGLE: next_wave = ~wave;
        OM_CLEAR:  next_wave = 1'b0;
        OM_SET:    next_wave = 1'b1;
      endcase
    end else if (!pwm_en) begin
      if (match) begin
        unique case (mode)
          OM_PORT:   next_wave = wave;
          OM_TOGGLE: next_wave = ~wave;
          OM_CLEAR:  next_wave = 1'b0;
          OM_SET:    next_wave = 1'b1;
        endcase
      end
    end else if (mode != OM_PORT) begin
      if (!dual) begin
        if (match) begin
          next_wave = mode == OM_SET;
        end else if (count == COUNT_BOTTOM) begin
          next_wave = mode != OM_SET;
        end
      end else if (match) begin
        next_wave = (mode == OM_SET) ^ count_down;
      end
    end
    next_pins = port_value_i;
    if (six) begin
      for (int k = 0; k < PIN_COUNT; k++) begin
        next_pins[k] = oe_bits[k] ? six_wave[k] : port_value_i[k];
      end
    end else if (!(fw.fault_protect_enable && fw.fault_flag)) begin
      next_pins[4] = (mode != OM_PORT) ? wave : port_value_i[4];
      next_pins[5] = (pwm_en && mode == OM_TOGGLE) ? ~wave : port_value_i[5];
    end
    next_irq = global_irq_en_i && fw.fault_irq_enable && fw.fault_flag;
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wave              <= 1'b0;
      src_prev          <= 1'b0;
      pin_out_o         <= 6'h00;
      pin_oe_o          <= 6'h00;
      fault_irq_o       <= 1'b0;
      chan_d_waveform_o <= 1'b0;
    end else begin
      wave              <= next_wave;
      src_prev          <= src_level;
      pin_out_o         <= next_pins;
      pin_oe_o          <= port_dir_i;
      fault_irq_o       <= next_irq;
      chan_d_waveform_o <= next_wave;
    end
  end

  // checks
  property p_force_reads_zero;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (reg_rd_i && reg_addr_i == ADDR_CHD_CTRL) |=> !reg_rdata_o[CHD_FORCE];
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero) else $error("force bit read as one");

  property p_reserved_zero;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (reg_rd_i && reg_addr_i == ADDR_HOLD) |=> reg_rdata_o[7:2] == 6'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("holding reserved bits nonzero");

  property p_top_min;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      top_buf >= TOP_MIN && top_act >= TOP_MIN;
  endproperty
  a_top_min: assert property (p_top_min) else $error("top below minimum");

  property p_count_write;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (reg_wr_i && reg_addr_i == ADDR_COUNTER) |=> ##1 (count == $past(cnt_val) && !count_down);
  endproperty
  a_count_write: assert property (p_count_write) else $error("counter write not applied upward");

  property p_inv_disconnected;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (!six && !(pwm_en && mode == OM_TOGGLE)) |=> pin_out_o[5] == $past(port_value_i[5]);
  endproperty
  a_inv_disconnected: assert property (p_inv_disconnected) else $error("inverted pin connected");

  property p_flag_set;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      fault_event |=> fw.fault_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("fault event lost");

  property p_sw_clear;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (reg_wr_i && reg_addr_i == ADDR_FAULT_WAVE && reg_wdata_i[FLT_FLAG] && !fault_event)
      ##1 !fault_event |=> !fw.fault_flag;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("flag not cleared by write");

  property p_irq_gate;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      fault_irq_o |-> $past(global_irq_en_i) && $past(fw.fault_irq_enable) && $past(fw.fault_flag);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without all enables");

  property p_nonpwm_set;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (!pwm_en && mode == OM_SET && match && !force_wr) |=> wave ##1 chan_d_waveform_o;
  endproperty
  a_nonpwm_set: assert property (p_nonpwm_set) else $error("set on match failed");

  property p_fast_bottom;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (pwm_en && !dual && mode == OM_CLEAR && count == COUNT_BOTTOM && !match && !force_wr) |=> wave;
  endproperty
  a_fast_bottom: assert property (p_fast_bottom) else $error("fast pwm not set at bottom");

endmodule : pwmd_timer
`default_nettype wire

// ===== logic/pwmd_pkg.sv
// Purpose: shared constants and types for the channel D / fault / wave-mode timer block
// Assumes: byte-wide cpu register port, one timer clock
// Notes:   offsets are 6-bit i/o addresses
package pwmd_pkg;

  localparam int          COUNT_W          = 10;
  localparam int          DATA_W           = 8;
  localparam int          ADDR_W           = 6;
  localparam int          PIN_COUNT        = 6;

  localparam logic [5:0]  ADDR_OVERRIDE    = 6'h20;
  localparam logic [5:0]  ADDR_CHD_CMP     = 6'h22;
  localparam logic [5:0]  ADDR_HOLD        = 6'h25;
  localparam logic [5:0]  ADDR_FAULT_WAVE  = 6'h26;
  localparam logic [5:0]  ADDR_CHD_CTRL    = 6'h27;
  localparam logic [5:0]  ADDR_TOP_CMP     = 6'h2B;
  localparam logic [5:0]  ADDR_COUNTER     = 6'h2E;

  // channel_d_output_ctrl field positions
  localparam int          CHD_MODE_HI      = 3;
  localparam int          CHD_MODE_LO      = 2;
  localparam int          CHD_FORCE        = 1;
  localparam int          CHD_PWM          = 0;
  // fault_and_wave_mode_ctrl flag position
  localparam int          FLT_FLAG         = 2;

  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam logic [5:0]  OVERRIDE_RESET   = 6'h00;
  localparam logic [1:0]  HOLD_RESET       = 2'h0;
  localparam logic [9:0]  TOP_RESET        = 10'h3FF;
  localparam logic [9:0]  CHD_CMP_RESET    = 10'h000;
  localparam logic [9:0]  COUNT_BOTTOM     = 10'h000;
  localparam logic [9:0]  TOP_MIN          = 10'h003;

  // equal samples needed before the filtered fault level may change
  localparam int          FILTER_SAMPLES   = 4;
  localparam logic [1:0]  FILTER_LAST      = 2'(FILTER_SAMPLES - 1);

  typedef enum logic [1:0] {
    OM_PORT   = 2'h0,
    OM_TOGGLE = 2'h1,
    OM_CLEAR  = 2'h2,
    OM_SET    = 2'h3
  } pwmd_out_mode_e;

  typedef struct packed {
    logic       fault_irq_enable;
    logic       fault_protect_enable;
    logic       fault_noise_filter_en;
    logic       fault_edge_select;
    logic       fault_comparator_source;
    logic       fault_flag;
    logic       waveform_mode_sel_hi;
    logic       waveform_mode_sel_lo;
  } pwmd_fault_wave_s;

endpackage : pwmd_pkg

// ===== logic/pwmd_fault_front.sv
// Purpose: fault input synchroniser and four-sample noise filter
// Assumes: raw input is asynchronous to sys_clk_i
// Notes:   filtered level lags the synchronised one by four samples
`timescale 1ns/1ps
`default_nettype none
module pwmd_fault_front (
  input  wire logic sys_clk_i,    // timer clock
  input  wire logic sys_rst_i,    // async reset, high
  input  wire logic raw_i,        // asynchronous fault source
  input  wire logic filter_en_i,  // noise filter enable
  output logic      level_o       // conditioned level
);
  import pwmd_pkg::*;

  logic       sync_a;
  logic       sync_b;
  logic       filt;
  logic [1:0] run;
  logic       next_filt;
  logic [1:0] next_run;

  always_comb begin
    next_filt = filt;
    next_run  = 2'h0;
    if (sync_b != filt) begin
      if (run == FILTER_LAST) begin
        next_filt = sync_b;
      end else begin
        next_run = run + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      filt   <= 1'b0;
      run    <= 2'h0;
    end else begin
      sync_a <= raw_i;
      sync_b <= sync_a;
      filt   <= next_filt;
      run    <= next_run;
    end
  end

  assign level_o = filter_en_i ? filt : sync_b;

endmodule : pwmd_fault_front
`default_nettype wire

// ===== tb/pwmd_far_side.sv
// Purpose: power stage and fault sources facing the timer pins
// Assumes: one timer clock; requests come from the bench
// Notes:   pins that are not driven read low through the stage pull-downs
`timescale 1ns/1ps
`default_nettype none
module pwmd_far_side (
  input  wire logic       sys_clk_i,   // timer clock
  input  wire logic       fault_req_i, // wanted fault level
  input  wire logic       cmp_req_i,   // wanted comparator level
  input  wire logic [5:0] pin_out_i,   // device pin levels
  input  wire logic [5:0] pin_oe_i,    // device drive enables
  output var  logic       fault_pin_o, // fault pin to device
  output var  logic       cmp_out_o,   // comparator to device
  output logic      [5:0] pin_lvl_o    // resolved pin levels
);
  initial begin
    fault_pin_o = 1'b0;
    cmp_out_o   = 1'b0;
  end
  // sources change just after the clock edge
  always @(posedge sys_clk_i) begin
    fault_pin_o <= fault_req_i;
    cmp_out_o   <= cmp_req_i;
  end
  assign pin_lvl_o = pin_out_i & pin_oe_i;
endmodule : pwmd_far_side
`default_nettype wire

// ===== tb/pwmd_timer_test.sv
// Purpose: self-checking bench for the channel d, fault and wave-mode timer
// Assumes: 20 MHz clock, strobed byte register port
// Notes:   top compare set to its minimum so pwm periods stay short
`timescale 1ns/1ps
`default_nettype none
module pwmd_timer_test;
  import pwmd_pkg::*;
  logic       sys_clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [5:0] addr = '0;
  logic [7:0] wdata = '0;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       gie = 1'b0;
  logic       ack = 1'b0;
  logic       flt_req = 1'b0;
  logic       cmp_req = 1'b0;
  logic [5:0] dir = '0;
  logic [7:0] rdata;
  logic [5:0] pin_out, pin_oe, pin_lvl;
  logic       irq, ovf, wave, flt_pin, cmp_out;
  int         err_count = 0;
  int         n_compared = 0;

  always #25 sys_clk_i = ~sys_clk_i;

  pwmd_timer pwmd_timer_inst (.sys_clk_i, .sys_rst_i, .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .global_irq_en_i(gie),
    .fault_vector_ack_i(ack), .external_fault_pin_i(flt_pin), .comparator_out_i(cmp_out),
    .port_value_i(6'h2A), .port_dir_i(dir), .other_waveforms_i(4'h5), .pin_out_o(pin_out),
    .pin_oe_o(pin_oe), .fault_irq_o(irq), .counter_overflow_o(ovf), .chan_d_waveform_o(wave));

  pwmd_far_side pwmd_far_side_inst (.sys_clk_i, .fault_req_i(flt_req), .cmp_req_i(cmp_req),
    .pin_out_i(pin_out), .pin_oe_i(pin_oe), .fault_pin_o(flt_pin), .cmp_out_o(cmp_out),
    .pin_lvl_o(pin_lvl));

  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : cyc

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk_i);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk_i);
    rd   <= 1'b0;
    cyc(1);
    chk(what, {2'b00, rdata}, {2'b00, exp});
  endtask : rd_chk

  task automatic drive(input logic f, input logic c);
    @(posedge sys_clk_i);
    flt_req <= f;
    cmp_req <= c;
  endtask : drive

  task automatic wait_irq(input string what);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 20) begin
      cyc(1);
      k++;
    end
    chk(what, irq, 1'b1);
    if (k == 20) conclude();
  endtask : wait_irq

  // counts waveform, pin and overflow highs over n cycles
  task automatic sample(input int n, input logic [9:0] hi, input logic [9:0] p5, input logic [9:0] ov);
    logic [9:0] w, p4, q5, o;
    w = 0; p4 = 0; q5 = 0; o = 0;
    repeat (n) begin
      cyc(1);
      w += wave; p4 += pin_lvl[4]; q5 += pin_lvl[5]; o += ovf;
    end
    chk("wave highs", w, hi);
    chk("pin d highs", p4, hi);
    chk("pin d inv highs", q5, p5);
    chk("overflows", o, ov);
  endtask : sample

  task automatic t_regs();
    rd_chk(ADDR_FAULT_WAVE, CTRL_RESET, "fault_wave reset");
    rd_chk(ADDR_CHD_CTRL, CTRL_RESET, "chd_ctrl reset");
    rd_chk(6'h3F, 8'h00, "unmapped");
    wr_reg(ADDR_OVERRIDE, 8'hFF);
    rd_chk(ADDR_OVERRIDE, 8'h3F, "override");
    wr_reg(ADDR_OVERRIDE, 8'h00);
    wr_reg(ADDR_HOLD, 8'hFF);
    rd_chk(ADDR_HOLD, 8'h03, "hold");
    wr_reg(ADDR_HOLD, 8'h01);
    wr_reg(ADDR_COUNTER, 8'h00);
    wr_reg(ADDR_HOLD, 8'h00);
    rd_chk(ADDR_COUNTER, 8'h02, "counter low");
    rd_chk(ADDR_HOLD, 8'h01, "counter high");
  endtask : t_regs

  task automatic t_force();
    logic [7:0] code [4] = '{8'h0E, 8'h0A, 8'h06, 8'h02};
    logic [3:0] exp = 4'b0101;
    for (int i = 0; i < 4; i++) begin
      wr_reg(ADDR_CHD_CTRL, code[i]);
      cyc(3);
      chk("forced pin", pin_lvl[4], exp[i]);
    end
    rd_chk(ADDR_CHD_CTRL, 8'h00, "force reads zero");
  endtask : t_force

  task automatic t_pwm();
    wr_reg(ADDR_HOLD, 8'h00);
    wr_reg(ADDR_TOP_CMP, 8'h01);
    rd_chk(ADDR_TOP_CMP, 8'h03, "top minimum");
    wr_reg(ADDR_CHD_CMP, 8'h01);
    wr_reg(ADDR_CHD_CTRL, 8'h08);
    cyc(6);
    chk("clear on match", wave, 1'b0);
    wr_reg(ADDR_CHD_CTRL, 8'h0C);
    cyc(6);
    chk("set on match", wave, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wr_reg(ADDR_CHD_CTRL, {4'h0, 2'(i + 1), 2'b01});
      cyc(8);
      sample(8, (i == 2) ? 10'd6 : 10'd2, (i == 0) ? 10'd6 : 10'd8, 10'd2);
    end
    wr_reg(ADDR_FAULT_WAVE, 8'h01);
    wr_reg(ADDR_CHD_CTRL, 8'h05);
    cyc(12);
    sample(12, 10'd4, 10'd8, 10'd2);
    wr_reg(ADDR_CHD_CTRL, 8'h0D);
    cyc(12);
    sample(12, 10'd8, 10'd12, 10'd2);
    wr_reg(ADDR_FAULT_WAVE, 8'h02);
    wr_reg(ADDR_OVERRIDE, 8'h03);
    cyc(4);
    chk("override on", pin_lvl[1:0], 2'b01);
    wr_reg(ADDR_OVERRIDE, 8'h00);
    cyc(4);
    chk("override off", pin_lvl[1:0], 2'b10);
    wr_reg(ADDR_CHD_CTRL, 8'h00);
  endtask : t_pwm

  task automatic t_fault();
    wr_reg(ADDR_FAULT_WAVE, 8'h90);
    drive(1'b1, 1'b0);
    wait_irq("rise event");
    rd_chk(ADDR_FAULT_WAVE, 8'h94, "flag set");
    wr_reg(ADDR_FAULT_WAVE, 8'h94);
    cyc(4);
    chk("write clear", irq, 1'b0);
    drive(1'b0, 1'b0);
    cyc(8);
    chk("fall ignored", irq, 1'b0);
    drive(1'b1, 1'b0);
    wait_irq("second rise");
    @(posedge sys_clk_i);
    ack <= 1'b1;
    @(posedge sys_clk_i);
    ack <= 1'b0;
    cyc(2);
    chk("vector clear", irq, 1'b0);
    drive(1'b0, 1'b0);
    wr_reg(ADDR_FAULT_WAVE, 8'hB0);
    cyc(8);
    drive(1'b1, 1'b0);
    drive(1'b0, 1'b0);
    cyc(12);
    chk("glitch filtered", irq, 1'b0);
    drive(1'b1, 1'b0);
    wait_irq("filtered rise");
    drive(1'b0, 1'b0);
    wr_reg(ADDR_FAULT_WAVE, 8'hB4);
    wr_reg(ADDR_FAULT_WAVE, 8'h98);
    drive(1'b1, 1'b0);
    cyc(10);
    chk("pin unlinked", irq, 1'b0);
    drive(1'b1, 1'b1);
    wait_irq("comparator rise");
    @(posedge sys_clk_i);
    gie <= 1'b0;
    cyc(3);
    chk("global off", irq, 1'b0);
    rd_chk(ADDR_FAULT_WAVE, 8'h9C, "flag kept");
  endtask : t_fault

  initial begin
    repeat (20) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    dir       <= 6'h3F;
    gie       <= 1'b1;
    t_regs();
    t_force();
    t_pwm();
    t_fault();
    conclude();
  end
endmodule : pwmd_timer_test
`default_nettype wire
